// >>> olcfg_pkg.sv
// Constants for the optical emitter drive configuration block
package olcfg_pkg;
  localparam int unsigned OLCFG_ADDR_W = 8;
  localparam int unsigned OLCFG_DATA_W = 32;
  localparam int unsigned OLCFG_NUM_EMITTERS = 3;
  localparam int unsigned OLCFG_CODE_W = 8;
  localparam int unsigned OLCFG_RANGE_W = 2;
  localparam int unsigned OLCFG_SUBR_W = 6;
  localparam int unsigned OLCFG_SEL_W = 4;
  localparam int unsigned OLCFG_EXP_W = 3;
  localparam int unsigned OLCFG_CURRENT_W = 17;

  // Register indices; byte address is four times the index
  localparam logic [5:0] OLCFG_IDX_SLOTS_34 = 6'h21;
  localparam logic [5:0] OLCFG_IDX_SLOTS_56 = 6'h22;
  localparam logic [5:0] OLCFG_IDX_EMITTER1 = 6'h23;
  localparam logic [5:0] OLCFG_IDX_EMITTER2 = 6'h24;
  localparam logic [5:0] OLCFG_IDX_EMITTER3 = 6'h25;
  localparam logic [5:0] OLCFG_IDX_PROBE = 6'h29;
  localparam logic [5:0] OLCFG_IDX_FULL_SCALE = 6'h2A;
  localparam logic [5:0] OLCFG_IDX_EXPOSURE1 = 6'h2C;
  localparam logic [5:0] OLCFG_IDX_EXPOSURE2 = 6'h2D;

  // Field positions
  localparam int unsigned OLCFG_SLOT_HI_LSB = 4;
  localparam int unsigned OLCFG_SW_CONTROL_BIT = 7;
  localparam int unsigned OLCFG_FULL_SCALE_MASK_W = 6;

  // Reset values
  localparam logic [7:0] OLCFG_RST_BYTE = 8'h00;
  localparam logic [1:0] OLCFG_RST_RANGE = 2'h0;
  localparam logic [5:0] OLCFG_RST_SUBR = 6'h00;
  localparam logic [16:0] OLCFG_RST_CURRENT = 17'h00000;

  // Exposure numbering on exposure_sel
  localparam logic [2:0] OLCFG_EXPOSURE_1 = 3'h0;
  localparam logic [2:0] OLCFG_EXPOSURE_2 = 3'h1;

  // Drive step per code for range 00, in microamps; range n is (n+1) steps
  localparam int unsigned OLCFG_STEP_UA = 120;

  // AXI responses
  localparam logic [1:0] OLCFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] OLCFG_RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {
    OLCFG_WR_COLLECT = 1'b0,
    OLCFG_WR_RESP = 1'b1
  } olcfg_wr_state_t;

  typedef enum logic [0:0] {
    OLCFG_RD_IDLE = 1'b0,
    OLCFG_RD_DATA = 1'b1
  } olcfg_rd_state_t;
endpackage : olcfg_pkg

// >>> olcfg_drive_if.sv
// Settings handed from the register bank to one emitter driver
`timescale 1ns/10ps
interface olcfg_drive_if;
  logic [7:0] normal_code;
  logic [7:0] probe_code;
  logic [1:0] full_scale;
  logic use_probe;
  logic load;
  modport src (
    output normal_code,
    output probe_code,
    output full_scale,
    output use_probe,
    output load
  );
  modport drv (
    input normal_code,
    input probe_code,
    input full_scale,
    input use_probe,
    input load
  );
endinterface : olcfg_drive_if

// >>> olcfg_emitter_drive.sv
// One emitter driver setting, latched at each exposure start
`timescale 1ns/10ps
module olcfg_emitter_drive
  import olcfg_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  olcfg_drive_if.drv cfg,
  output logic [7:0] drive_code,
  output logic [1:0] full_scale,
  output logic [16:0] current_ua
);
  logic [7:0] code_reg;
  logic [7:0] code_next;
  logic [1:0] range_reg;
  logic [1:0] range_next;
  logic [16:0] current_reg;
  logic [16:0] current_next;
  logic [7:0] chosen;

  always_comb
  begin
    code_next = code_reg;
    range_next = range_reg;
    current_next = current_reg;
    chosen = cfg.use_probe ? cfg.probe_code : cfg.normal_code;
    if (cfg.load)
    begin
      code_next = chosen;
      range_next = cfg.full_scale;
      // Code times step times (range + 1); zero code gives zero current
      current_next = 17'(32'(chosen) * OLCFG_STEP_UA
        * (32'(cfg.full_scale) + 32'd1));
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      code_reg <= OLCFG_RST_BYTE;
      range_reg <= OLCFG_RST_RANGE;
      current_reg <= OLCFG_RST_CURRENT;
    end
    else if (clk_en)
    begin
      code_reg <= code_next;
      range_reg <= range_next;
      current_reg <= current_next;
    end
  end

  assign drive_code = code_reg;
  assign full_scale = range_reg;
  assign current_ua = current_reg;
endmodule : olcfg_emitter_drive

// >>> olcfg_regs.sv
// Emitter drive and subranging configuration registers on AXI4-Lite
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module olcfg_regs
  import olcfg_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exposure_start,
  input wire logic [2:0] exposure_sel,
  input wire logic proximity_detect_mode,
  input wire logic multi_emitter_mode,
  input wire logic [5:0] chip_subrange_code,
  output logic [3:0] slot3_data_type,
  output logic [3:0] slot4_data_type,
  output logic [3:0] slot5_data_type,
  output logic [3:0] slot6_data_type,
  output logic [2:0][7:0] emitter_drive_code,
  output logic [2:0][1:0] emitter_drive_range,
  output logic [2:0][16:0] emitter_current_ua,
  output logic [5:0] first_photodiode_channel_dac,
  output logic first_photodiode_channel_sw
);
  // Bus write path
  olcfg_wr_state_t wr_state_reg;
  olcfg_wr_state_t wr_state_next;
  logic aw_held_reg;
  logic aw_held_next;
  logic [5:0] aw_idx_reg;
  logic [5:0] aw_idx_next;
  logic w_held_reg;
  logic w_held_next;
  logic [7:0] w_byte_reg;
  logic [7:0] w_byte_next;
  logic w_lane_reg;
  logic w_lane_next;
  logic awready_reg;
  logic awready_next;
  logic wready_reg;
  logic wready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic wr_fire;

  // Bus read path
  olcfg_rd_state_t rd_state_reg;
  olcfg_rd_state_t rd_state_next;
  logic arready_reg;
  logic arready_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;

  // Register file
  logic [7:0] slots34_reg;
  logic [7:0] slots34_next;
  logic [7:0] slots56_reg;
  logic [7:0] slots56_next;
  logic [2:0][7:0] emitter_code_reg;
  logic [2:0][7:0] emitter_code_next;
  logic [7:0] probe_current_reg;
  logic [7:0] probe_current_next;
  logic [5:0] full_scale_reg;
  logic [5:0] full_scale_next;
  logic [1:0][7:0] exposure_reg;
  logic [1:0][7:0] exposure_next;

  // Exposure DAC selection
  logic [5:0] dac_reg;
  logic [5:0] dac_next;
  logic dac_sw_reg;
  logic dac_sw_next;

  // Read decode
  function automatic logic [8:0] olcfg_read_byte(
    input logic [5:0] idx,
    input logic [7:0] s34,
    input logic [7:0] s56,
    input logic [2:0][7:0] codes,
    input logic [7:0] probe,
    input logic [5:0] fs,
    input logic [1:0][7:0] expo
  );
    logic [8:0] res;
    res = {1'b1, OLCFG_RST_BYTE};
    case (idx)
      OLCFG_IDX_SLOTS_34: res = {1'b0, s34};
      OLCFG_IDX_SLOTS_56: res = {1'b0, s56};
      OLCFG_IDX_EMITTER1: res = {1'b0, codes[0]};
      OLCFG_IDX_EMITTER2: res = {1'b0, codes[1]};
      OLCFG_IDX_EMITTER3: res = {1'b0, codes[2]};
      OLCFG_IDX_PROBE: res = {1'b0, probe};
      OLCFG_IDX_FULL_SCALE: res = {3'b000, fs};
      OLCFG_IDX_EXPOSURE1: res = {1'b0, expo[0][7], 1'b0, expo[0][5:0]};
      OLCFG_IDX_EXPOSURE2: res = {1'b0, expo[1][7], 1'b0, expo[1][5:0]};
      default: res = {1'b1, OLCFG_RST_BYTE};
    endcase
    return res;
  endfunction : olcfg_read_byte

  logic [8:0] rd_lookup;
  logic [8:0] wr_lookup;

  // Write channel handling: address and data in either order
  always_comb
  begin
    wr_state_next = wr_state_reg;
    aw_held_next = aw_held_reg;
    aw_idx_next = aw_idx_reg;
    w_held_next = w_held_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    wr_fire = 1'b0;
    wr_lookup = olcfg_read_byte(aw_idx_reg, slots34_reg, slots56_reg,
      emitter_code_reg, probe_current_reg, full_scale_reg, exposure_reg);
    case (wr_state_reg)
      OLCFG_WR_COLLECT:
      begin
        if (s_axi_awvalid && awready_reg)
        begin
          aw_held_next = 1'b1;
          aw_idx_next = s_axi_awaddr[7:2];
        end
        if (s_axi_wvalid && wready_reg)
        begin
          w_held_next = 1'b1;
          w_byte_next = s_axi_wdata[7:0];
          w_lane_next = s_axi_wstrb[0];
        end
        if (aw_held_reg && w_held_reg)
        begin
          wr_fire = 1'b1;
          bvalid_next = 1'b1;
          bresp_next = wr_lookup[8] ? OLCFG_RESP_DECERR : OLCFG_RESP_OKAY;
          wr_state_next = OLCFG_WR_RESP;
        end
      end
      OLCFG_WR_RESP:
      begin
        if (s_axi_bready)
        begin
          bvalid_next = 1'b0;
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          wr_state_next = OLCFG_WR_COLLECT;
        end
      end
      default:
      begin
        wr_state_next = OLCFG_WR_COLLECT;
      end
    endcase
    awready_next = (wr_state_next == OLCFG_WR_COLLECT) && !aw_held_next;
    wready_next = (wr_state_next == OLCFG_WR_COLLECT) && !w_held_next;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_state_reg <= OLCFG_WR_COLLECT;
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      w_held_reg <= 1'b0;
      w_byte_reg <= OLCFG_RST_BYTE;
      w_lane_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= OLCFG_RESP_OKAY;
    end
    else if (clk_en)
    begin
      wr_state_reg <= wr_state_next;
      aw_held_reg <= aw_held_next;
      aw_idx_reg <= aw_idx_next;
      w_held_reg <= w_held_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // Read channel: one-cycle answer
  always_comb
  begin
    rd_state_next = rd_state_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rd_lookup = olcfg_read_byte(s_axi_araddr[7:2], slots34_reg, slots56_reg,
      emitter_code_reg, probe_current_reg, full_scale_reg, exposure_reg);
    case (rd_state_reg)
      OLCFG_RD_IDLE:
      begin
        if (s_axi_arvalid && arready_reg)
        begin
          rdata_next = {24'h000000, rd_lookup[7:0]};
          rresp_next = rd_lookup[8] ? OLCFG_RESP_DECERR : OLCFG_RESP_OKAY;
          rd_state_next = OLCFG_RD_DATA;
        end
      end
      OLCFG_RD_DATA:
      begin
        if (s_axi_rready)
        begin
          rd_state_next = OLCFG_RD_IDLE;
        end
      end
      default:
      begin
        rd_state_next = OLCFG_RD_IDLE;
      end
    endcase
    arready_next = (rd_state_next == OLCFG_RD_IDLE);
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_state_reg <= OLCFG_RD_IDLE;
      arready_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= OLCFG_RESP_OKAY;
    end
    else if (clk_en)
    begin
      rd_state_reg <= rd_state_next;
      arready_reg <= arready_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // Register file writes, low byte lane only
  always_comb
  begin
    slots34_next = slots34_reg;
    slots56_next = slots56_reg;
    emitter_code_next = emitter_code_reg;
    probe_current_next = probe_current_reg;
    full_scale_next = full_scale_reg;
    exposure_next = exposure_reg;
    if (wr_fire && w_lane_reg)
    begin
      case (aw_idx_reg)
        OLCFG_IDX_SLOTS_34: slots34_next = w_byte_reg;
        OLCFG_IDX_SLOTS_56: slots56_next = w_byte_reg;
        OLCFG_IDX_EMITTER1: emitter_code_next[0] = w_byte_reg;
        OLCFG_IDX_EMITTER2: emitter_code_next[1] = w_byte_reg;
        OLCFG_IDX_EMITTER3: emitter_code_next[2] = w_byte_reg;
        OLCFG_IDX_PROBE: probe_current_next = w_byte_reg;
        OLCFG_IDX_FULL_SCALE:
          full_scale_next = w_byte_reg[OLCFG_FULL_SCALE_MASK_W-1:0];
        OLCFG_IDX_EXPOSURE1: exposure_next[0] = w_byte_reg;
        OLCFG_IDX_EXPOSURE2: exposure_next[1] = w_byte_reg;
        default: slots34_next = slots34_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      slots34_reg <= OLCFG_RST_BYTE;
      slots56_reg <= OLCFG_RST_BYTE;
      emitter_code_reg <= '0;
      probe_current_reg <= OLCFG_RST_BYTE;
      full_scale_reg <= 6'h00;
      exposure_reg <= '0;
    end
    else if (clk_en)
    begin
      slots34_reg <= slots34_next;
      slots56_reg <= slots56_next;
      emitter_code_reg <= emitter_code_next;
      probe_current_reg <= probe_current_next;
      full_scale_reg <= full_scale_next;
      exposure_reg <= exposure_next;
    end
  end

  // Subranging DAC code, chosen once per exposure
  always_comb
  begin
    dac_next = dac_reg;
    dac_sw_next = dac_sw_reg;
    if (exposure_start)
    begin
      dac_next = chip_subrange_code;
      dac_sw_next = 1'b0;
      if (exposure_sel == OLCFG_EXPOSURE_1
        && exposure_reg[0][OLCFG_SW_CONTROL_BIT])
      begin
        dac_next = exposure_reg[0][OLCFG_SUBR_W-1:0];
        dac_sw_next = 1'b1;
      end
      else if (exposure_sel == OLCFG_EXPOSURE_2
        && exposure_reg[1][OLCFG_SW_CONTROL_BIT])
      begin
        dac_next = exposure_reg[1][OLCFG_SUBR_W-1:0];
        dac_sw_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dac_reg <= OLCFG_RST_SUBR;
      dac_sw_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      dac_reg <= dac_next;
      dac_sw_reg <= dac_sw_next;
    end
  end

  // Emitter drivers latch code and range at exposure start
  olcfg_drive_if drv_if[OLCFG_NUM_EMITTERS] ();

  genvar gi;
  generate
    for (gi = 0; gi < OLCFG_NUM_EMITTERS; gi++)
    begin : g_emitter
      assign drv_if[gi].normal_code = emitter_code_reg[gi];
      assign drv_if[gi].probe_code = probe_current_reg;
      assign drv_if[gi].full_scale = full_scale_reg[2*gi+1:2*gi];
      assign drv_if[gi].use_probe =
        proximity_detect_mode | multi_emitter_mode;
      assign drv_if[gi].load = exposure_start;
      olcfg_emitter_drive u_drive (
        .mclk(mclk),
        .resetn(resetn),
        .clk_en(clk_en),
        .cfg(drv_if[gi]),
        .drive_code(emitter_drive_code[gi]),
        .full_scale(emitter_drive_range[gi]),
        .current_ua(emitter_current_ua[gi])
      );
    end
  endgenerate

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = (rd_state_reg == OLCFG_RD_DATA);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign slot3_data_type = slots34_reg[OLCFG_SEL_W-1:0];
  assign slot4_data_type = slots34_reg[7:OLCFG_SLOT_HI_LSB];
  assign slot5_data_type = slots56_reg[OLCFG_SEL_W-1:0];
  assign slot6_data_type = slots56_reg[7:OLCFG_SLOT_HI_LSB];
  assign first_photodiode_channel_dac = dac_reg;
  assign first_photodiode_channel_sw = dac_sw_reg;
endmodule : olcfg_regs

// >>> olcfg_regs_checker.sv
// Port-level assertions for the emitter drive configuration registers
`timescale 1ns/10ps
module olcfg_regs_checker
  import olcfg_pkg::*;
(
  input logic mclk,
  input logic resetn,
  input logic clk_en,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic s_axi_rvalid,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic exposure_start,
  input logic [2:0] exposure_sel,
  input logic proximity_detect_mode,
  input logic multi_emitter_mode,
  input logic [5:0] chip_subrange_code,
  input logic [2:0][7:0] emitter_drive_code,
  input logic [2:0][1:0] emitter_drive_range,
  input logic [2:0][16:0] emitter_current_ua,
  input logic [5:0] first_photodiode_channel_dac,
  input logic first_photodiode_channel_sw
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  function automatic logic [16:0] ua(logic [7:0] c, logic [1:0] r);
    return 17'(32'(c) * OLCFG_STEP_UA * (32'(r) + 1));
  endfunction : ua

  AST_CUR1: assert property (
    emitter_current_ua[0]
    == ua(emitter_drive_code[0], emitter_drive_range[0]))
    else $error("emitter 1 current does not match code and range");
  AST_CUR23: assert property (
    emitter_current_ua[1] == ua(emitter_drive_code[1], emitter_drive_range[1])
    && emitter_current_ua[2] == ua(emitter_drive_code[2],
    emitter_drive_range[2])) else $error("emitter 2 or 3 current wrong");
  AST_HOLD: assert property (
    clk_en && !exposure_start |=> $stable(emitter_drive_code)
    && $stable(emitter_drive_range)) else $error("drive changed mid exposure");
  AST_DAC_HOLD: assert property (
    clk_en && !exposure_start |=> $stable(first_photodiode_channel_dac)
    && $stable(first_photodiode_channel_sw)) else $error("dac changed");
  AST_PROBE: assert property (
    clk_en && exposure_start && (proximity_detect_mode || multi_emitter_mode)
    |=> emitter_drive_code[0] == emitter_drive_code[1]
    && emitter_drive_code[1] == emitter_drive_code[2])
    else $error("probe code not shared by all emitters");
  AST_OTHER_EXP: assert property (
    clk_en && exposure_start && exposure_sel > OLCFG_EXPOSURE_2
    |=> !first_photodiode_channel_sw
    && first_photodiode_channel_dac == $past(chip_subrange_code))
    else $error("later exposure not on chip code");
  AST_CHIP_CODE: assert property (
    clk_en && exposure_start ##1 !first_photodiode_channel_sw
    |-> first_photodiode_channel_dac == $past(chip_subrange_code))
    else $error("chip control but dac differs from chip code");
  AST_READ_LAT: assert property (
    clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  AST_RDATA_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bytes not zero");
  AST_B_DONE: assert property (
    clk_en && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  AST_FREEZE: assert property (
    !clk_en |=> $stable(emitter_drive_code)
    && $stable(first_photodiode_channel_dac))
    else $error("exposure state moved while clock enable low");
endmodule : olcfg_regs_checker

bind olcfg_regs olcfg_regs_checker olcfg_regs_checker_i (
  .mclk(mclk), .resetn(resetn), .clk_en(clk_en),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .exposure_start(exposure_start), .exposure_sel(exposure_sel),
  .proximity_detect_mode(proximity_detect_mode),
  .multi_emitter_mode(multi_emitter_mode),
  .chip_subrange_code(chip_subrange_code),
  .emitter_drive_code(emitter_drive_code),
  .emitter_drive_range(emitter_drive_range),
  .emitter_current_ua(emitter_current_ua),
  .first_photodiode_channel_dac(first_photodiode_channel_dac),
  .first_photodiode_channel_sw(first_photodiode_channel_sw)
);

// >>> olcfg_regs_tb.sv
// Self-checking bench for the emitter drive configuration registers
`timescale 1ns/10ps
`define CHK(a, e) chk(32'(a), 32'(e))
module olcfg_regs_tb
  import olcfg_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, exposure_start = 1'b0;
  logic [2:0] exposure_sel = 3'h0;
  logic proximity_detect_mode = 1'b0, multi_emitter_mode = 1'b0;
  logic [5:0] chip_subrange_code = 6'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, first_photodiode_channel_sw;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [3:0] slot3_data_type, slot4_data_type;
  logic [3:0] slot5_data_type, slot6_data_type;
  logic [2:0][7:0] emitter_drive_code;
  logic [2:0][1:0] emitter_drive_range;
  logic [2:0][16:0] emitter_current_ua;
  logic [5:0] first_photodiode_channel_dac;
  int n_errors = 0, num_checks = 0;
  localparam logic [5:0] IDX [9] = '{OLCFG_IDX_SLOTS_34, OLCFG_IDX_SLOTS_56,
    OLCFG_IDX_EMITTER1, OLCFG_IDX_EMITTER2, OLCFG_IDX_EMITTER3,
    OLCFG_IDX_PROBE, OLCFG_IDX_FULL_SCALE, OLCFG_IDX_EXPOSURE1,
    OLCFG_IDX_EXPOSURE2};
  localparam logic [7:0] WRV [9] = '{8'hC3, 8'h5A, 8'hFF, 8'h01, 8'h80,
    8'h7E, 8'hE4, 8'hFF, 8'h05};
  localparam logic [7:0] RDV [9] = '{8'hC3, 8'h5A, 8'hFF, 8'h01, 8'h80,
    8'h7E, 8'h24, 8'hBF, 8'h05};

  olcfg_regs olcfg_regs_i (.mclk, .resetn, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .exposure_start, .exposure_sel, .proximity_detect_mode,
    .multi_emitter_mode, .chip_subrange_code, .slot3_data_type,
    .slot4_data_type, .slot5_data_type, .slot6_data_type,
    .emitter_drive_code, .emitter_drive_range, .emitter_current_ua,
    .first_photodiode_channel_dac, .first_photodiode_channel_sw);

  always #2 mclk = ~mclk;

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    num_checks++;
    if (a !== e)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, e);
    end
  endtask : chk

  function automatic logic [16:0] exp_ua(logic [7:0] c, logic [1:0] g);
    return 17'(32'(c) * OLCFG_STEP_UA * (32'(g) + 1));
  endfunction : exp_ua

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [5:0] i, input logic [7:0] v,
    input logic [3:0] st, output logic [1:0] resp);
    int t;
    t = 0;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'hA5A5A5, v};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end
    while (!s_axi_bvalid && t < 100);
    resp = s_axi_bresp;
    if (t >= 100) n_errors++;
  endtask : wr

  task automatic rd(input logic [5:0] i, output logic [31:0] v,
    output logic [1:0] resp);
    int t;
    t = 0;
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end
    while (!s_axi_rvalid && t < 100);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    if (t >= 100) n_errors++;
  endtask : rd

  // One start pulse, then settings seen one edge later
  task automatic expose(input logic [2:0] s, input logic p, input logic m,
    input logic [5:0] c);
    exposure_sel <= s;
    proximity_detect_mode <= p;
    multi_emitter_mode <= m;
    chip_subrange_code <= c;
    exposure_start <= 1'b1;
    @(posedge mclk);
    exposure_start <= 1'b0;
    @(posedge mclk);
  endtask : expose

  task print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  initial
  begin
    #20000;
    n_errors++;
    print_verdict;
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 9; i++)
    begin
      rd(IDX[i], d, r);
      `CHK(d, 32'h00000000);
      wr(IDX[i], WRV[i], 4'h1, r);
      `CHK(r, OLCFG_RESP_OKAY);
      rd(IDX[i], d, r);
      `CHK(d, RDV[i]);
      `CHK(r, OLCFG_RESP_OKAY);
    end
    `CHK(slot3_data_type, 4'h3);
    `CHK(slot4_data_type, 4'hC);
    `CHK(slot5_data_type, 4'hA);
    `CHK(slot6_data_type, 4'h5);
    wr(6'h26, 8'h55, 4'h1, r);
    `CHK(r, OLCFG_RESP_DECERR);
    rd(6'h26, d, r);
    `CHK(d, 32'h00000000);
    `CHK(r, OLCFG_RESP_DECERR);
    wr(OLCFG_IDX_EMITTER1, 8'h11, 4'h0, r);
    `CHK(r, OLCFG_RESP_OKAY);
    rd(OLCFG_IDX_EMITTER1, d, r);
    `CHK(d, 32'h000000FF);
    `CHK(emitter_drive_code, 24'h000000);
    expose(OLCFG_EXPOSURE_1, 1'b0, 1'b0, 6'h15);
    `CHK(emitter_drive_code, {8'h80, 8'h01, 8'hFF});
    `CHK(emitter_drive_range, {2'h2, 2'h1, 2'h0});
    `CHK(emitter_current_ua[0], 17'h07788);
    `CHK(emitter_current_ua[1], 17'h000F0);
    `CHK(emitter_current_ua[2], 17'h0B400);
    for (int i = 0; i < 3; i++)
      `CHK(emitter_current_ua[i], exp_ua(WRV[2+i], WRV[6][2*i +: 2]));
    `CHK(first_photodiode_channel_dac, 6'h3F);
    `CHK(first_photodiode_channel_sw, 1'b1);
    wr(OLCFG_IDX_EMITTER1, 8'h10, 4'h1, r);
    `CHK(emitter_drive_code[0], 8'hFF);
    expose(OLCFG_EXPOSURE_2, 1'b0, 1'b0, 6'h2A);
    `CHK(emitter_drive_code[0], 8'h10);
    `CHK(first_photodiode_channel_dac, 6'h2A);
    `CHK(first_photodiode_channel_sw, 1'b0);
    wr(OLCFG_IDX_EXPOSURE2, 8'h85, 4'h1, r);
    expose(OLCFG_EXPOSURE_2, 1'b0, 1'b0, 6'h2A);
    `CHK(first_photodiode_channel_dac, 6'h05);
    `CHK(first_photodiode_channel_sw, 1'b1);
    expose(3'h2, 1'b0, 1'b0, 6'h0C);
    `CHK(first_photodiode_channel_dac, 6'h0C);
    `CHK(first_photodiode_channel_sw, 1'b0);
    wr(OLCFG_IDX_EXPOSURE1, 8'h3F, 4'h1, r);
    expose(OLCFG_EXPOSURE_1, 1'b0, 1'b0, 6'h31);
    `CHK(first_photodiode_channel_dac, 6'h31);
    `CHK(first_photodiode_channel_sw, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      expose(OLCFG_EXPOSURE_1, m == 0, m == 1, 6'h00);
      for (int i = 0; i < 3; i++)
      begin
        `CHK(emitter_drive_code[i], 8'h7E);
        `CHK(emitter_current_ua[i], exp_ua(8'h7E, WRV[6][2*i +: 2]));
      end
    end
    // Frozen clock enable: a start pulse must be missed
    clk_en <= 1'b0;
    expose(OLCFG_EXPOSURE_2, 1'b0, 1'b0, 6'h11);
    `CHK(emitter_drive_code[0], 8'h7E);
    `CHK(first_photodiode_channel_dac, 6'h00);
    `CHK(first_photodiode_channel_sw, 1'b0);
    clk_en <= 1'b1;
    expose(OLCFG_EXPOSURE_2, 1'b0, 1'b0, 6'h11);
    `CHK(emitter_drive_code[0], 8'h10);
    `CHK(first_photodiode_channel_dac, 6'h05);
    `CHK(first_photodiode_channel_sw, 1'b1);
    // Reset in mid-run returns outputs and registers to zero
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    `CHK(emitter_drive_code, 24'h000000);
    `CHK(first_photodiode_channel_dac, 6'h00);
    `CHK(first_photodiode_channel_sw, 1'b0);
    `CHK(slot4_data_type, 4'h0);
    rd(OLCFG_IDX_PROBE, d, r);
    `CHK(d, 32'h00000000);
    `CHK(r, OLCFG_RESP_OKAY);
    print_verdict;
  end
endmodule : olcfg_regs_tb
